// File: rtl/sac_pkg.sv
// Package for the serial converter cycle control: constants and carried types
package sac_pkg;

  // Frame and cycle figures in serial clock periods
  localparam int unsigned SAMPLE_START_CLK  = 5;
  localparam int unsigned SAMPLE_CLKS       = 12;
  localparam int unsigned CONV_START_CLK    = 16;
  localparam int unsigned CONV_CLOCKS       = 14;
  localparam int unsigned CONV_SCLKS        = CONV_CLOCKS * 2;
  localparam int unsigned SDO_RELEASE_CLK   = 17;
  localparam int unsigned MUX_RESET_MIN_CLK = 4;
  localparam int unsigned MUX_RESET_MAX_CLK = 7;
  localparam int unsigned FRAME_BITS        = 16;
  localparam int unsigned RESULT_BITS       = 12;

  // Host clock limits, for the bench
  localparam int unsigned SCLK_MIN_KHZ     = 100;
  localparam int unsigned SCLK_MAX_KHZ     = 20000;
  localparam int unsigned SCLK_SPI_MAX_KHZ = 15000;
  localparam int unsigned SCLK_DSP_MAX_KHZ = 8000;

  // Reset values and rail clamp codes
  localparam logic [11:0] RESULT_RST = 12'h000;
  localparam logic [11:0] CODE_FULL  = 12'hfff;
  localparam logic [11:0] CODE_ZERO  = 12'h000;
  localparam logic [7:0]  CNT_RST    = 8'h00;

  typedef enum logic [1:0] {
    SAC_VAR_SINGLE,
    SAC_VAR_DUAL,
    SAC_VAR_PSEUDO
  } sac_variant_e;

  typedef enum {
    SAC_IDLE,
    SAC_WAIT,
    SAC_SAMPLE,
    SAC_CONVERT,
    SAC_DONE
  } sac_state_e;

  // Analog front end carrier
  typedef struct packed {
    logic        above_ref;
    logic        below_gnd;
    logic [11:0] code;
  } sac_analog_s;

  typedef struct packed {
    logic        sample_en;
    logic        convert_en;
    logic        powered;
    logic        channel;
  } sac_frontend_s;

endpackage : sac_pkg

// File: rtl/sac_ctrl.sv
// Cycle control of the 12-bit serial successive-approximation converter
`timescale 1ns/100ps

module sac_ctrl
  import sac_pkg::*;
(
  // Clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  nrst,
  // Strap-like configuration, same domain
  input  wire sac_pkg::sac_variant_e variant,
  input  wire logic                  dsp_select_mode,
  // Host pins
  input  wire logic                  sclk,
  input  wire logic                  cs_n,
  input  wire logic                  frame_sync_in,
  output logic                       sdo_o,
  output logic                       sdo_oe_n,
  // Analog front end
  input  wire sac_pkg::sac_analog_s  analog,
  output sac_pkg::sac_frontend_s     frontend,
  output logic                       result_invalid
);
  import sac_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [2:0] meta_r;
  logic [2:0] sync_r;
  logic [2:0] prev_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      meta_r <= 3'b110;
      sync_r <= 3'b110;
      prev_r <= 3'b110;
    end else begin
      meta_r <= {cs_n, frame_sync_in, sclk};
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  logic cs_s;
  logic fs_s;
  logic sck_s;
  logic cs_fall;
  logic cs_rise;
  logic fs_fall;
  logic fs_rise;
  logic sck_rise;
  logic sck_fall;

  assign cs_s     = sync_r[2];
  assign fs_s     = sync_r[1];
  assign sck_s    = sync_r[0];
  assign cs_fall  = prev_r[2] & ~cs_s;
  assign cs_rise  = ~prev_r[2] & cs_s;
  assign fs_fall  = prev_r[1] & ~fs_s;
  assign fs_rise  = ~prev_r[1] & fs_s;
  assign sck_rise = ~prev_r[0] & sck_s;
  assign sck_fall = prev_r[0] & ~sck_s;

  ////////////////////////////////////////////////////////////////////////
  // Cycle sequencer
  sac_state_e  state_r, state_nxt;
  logic [7:0]  fcnt_r, fcnt_nxt;
  logic [7:0]  rcnt_r, rcnt_nxt;
  logic [7:0]  ccnt_r, ccnt_nxt;
  logic [11:0] result_r, result_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic        chan_r, chan_nxt;
  logic        pwr_r, pwr_nxt;
  logic        inval_r, inval_nxt;
  logic        bad_r, bad_nxt;
  logic        drive_r, drive_nxt;
  logic        sdo_r, sdo_nxt;
  logic        dual_ctl;
  logic        start;
  logic        chg_fall;
  logic        frame_end;
  logic [11:0] code_now;

  // Dual control only on the single-channel part while the synchronised frame sync is low
  assign dual_ctl  = (variant == SAC_VAR_SINGLE) && !fs_s;
  assign chg_fall  = dsp_select_mode || (variant != SAC_VAR_SINGLE);
  assign frame_end = cs_rise || (dual_ctl && fs_rise && state_r != SAC_IDLE && !cs_s);

  // Start: select fall when frame sync high; frame sync fall while clock high
  always_comb begin
    start = 1'b0;
    if (cs_fall && fs_s) begin
      start = 1'b1;
    end
    if ((variant == SAC_VAR_SINGLE) && fs_fall && sck_s && !cs_s) begin
      start = 1'b1;
    end
  end

  // Clamp codes at the rails
  always_comb begin
    code_now = analog.code;
    if (analog.above_ref) begin
      code_now = CODE_FULL;
    end else if (analog.below_gnd) begin
      code_now = CODE_ZERO;
    end
  end

  always_comb begin
    state_nxt  = state_r;
    fcnt_nxt   = fcnt_r;
    rcnt_nxt   = rcnt_r;
    ccnt_nxt   = ccnt_r;
    result_nxt = result_r;
    shift_nxt  = shift_r;
    chan_nxt   = chan_r;
    pwr_nxt    = pwr_r;
    inval_nxt  = inval_r;
    bad_nxt    = bad_r;
    drive_nxt  = drive_r;
    sdo_nxt    = sdo_r;

    // Wake and drive output
    if (cs_fall || fs_rise) begin
      pwr_nxt = 1'b1;
    end
    if (cs_fall || (fs_rise && !cs_s && state_r == SAC_IDLE)) begin
      // Previous result loaded, MSB first, low nibble zero
      shift_nxt = {result_r, 4'h0};
      sdo_nxt   = result_r[11];
      drive_nxt = 1'b1;
      inval_nxt = bad_r;
      rcnt_nxt  = CNT_RST;
    end

    if (start) begin
      state_nxt = SAC_WAIT;
      fcnt_nxt  = CNT_RST;
      rcnt_nxt  = CNT_RST;
      bad_nxt   = 1'b0;
    end else begin
      if (sck_fall && state_r != SAC_IDLE) begin
        fcnt_nxt = fcnt_r + 8'h01;
      end
      // Data shifts on the chosen clock edge
      if (drive_r && ((chg_fall && sck_fall) || (!chg_fall && sck_rise))) begin
        shift_nxt = {shift_r[14:0], 1'b0};
        sdo_nxt   = shift_r[14];
      end
      if (sck_rise && drive_r) begin
        rcnt_nxt = rcnt_r + 8'h01;
        if (rcnt_r == 8'(SDO_RELEASE_CLK - 1)) begin
          drive_nxt = 1'b0;
        end
      end
      case (state_r)
        SAC_IDLE: begin
        end
        SAC_WAIT: begin
          if (sck_fall && fcnt_r == 8'(SAMPLE_START_CLK - 2)) begin
            state_nxt = SAC_SAMPLE;
          end
        end
        SAC_SAMPLE: begin
          if (sck_fall && fcnt_r == 8'(CONV_START_CLK - 1)) begin
            state_nxt = SAC_CONVERT;
            ccnt_nxt  = CNT_RST;
          end
        end
        SAC_CONVERT: begin
          if (sck_fall) begin
            ccnt_nxt = ccnt_r + 8'h01;
            if (ccnt_r == 8'(CONV_SCLKS - 1)) begin
              state_nxt  = SAC_DONE;
              result_nxt = code_now;
              pwr_nxt    = 1'b0;
            end
          end
        end
        SAC_DONE: begin
        end
        default: state_nxt = SAC_IDLE;
      endcase
      if (frame_end && state_r != SAC_IDLE) begin
        if (state_r != SAC_DONE) begin
          bad_nxt = 1'b1;
          pwr_nxt = 1'b0;
        end
        state_nxt = SAC_IDLE;
      end
    end

    if (cs_rise) begin
      drive_nxt = 1'b0;
      if (variant == SAC_VAR_DUAL) begin
        if (rcnt_r >= 8'(MUX_RESET_MIN_CLK) && rcnt_r <= 8'(MUX_RESET_MAX_CLK)) begin
          chan_nxt = 1'b0;
        end else begin
          chan_nxt = ~chan_r;
        end
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      state_r  <= SAC_IDLE;
      fcnt_r   <= CNT_RST;
      rcnt_r   <= CNT_RST;
      ccnt_r   <= CNT_RST;
      result_r <= RESULT_RST;
      shift_r  <= 16'h0000;
      chan_r   <= 1'b0;
      pwr_r    <= 1'b0;
      inval_r  <= 1'b0;
      bad_r    <= 1'b0;
      drive_r  <= 1'b0;
      sdo_r    <= 1'b0;
    end else begin
      state_r  <= state_nxt;
      fcnt_r   <= fcnt_nxt;
      rcnt_r   <= rcnt_nxt;
      ccnt_r   <= ccnt_nxt;
      result_r <= result_nxt;
      shift_r  <= shift_nxt;
      chan_r   <= chan_nxt;
      pwr_r    <= pwr_nxt;
      inval_r  <= inval_nxt;
      bad_r    <= bad_nxt;
      drive_r  <= drive_nxt;
      sdo_r    <= sdo_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Outputs, all from flip-flops
  logic samp_r;
  logic conv_r;

  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      samp_r <= 1'b0;
      conv_r <= 1'b0;
    end else begin
      samp_r <= (state_nxt == SAC_SAMPLE);
      conv_r <= (state_nxt == SAC_CONVERT);
    end
  end

  assign sdo_o          = sdo_r;
  assign sdo_oe_n       = ~drive_r;
  assign result_invalid = inval_r;
  assign frontend       = '{sample_en: samp_r, convert_en: conv_r,
                            powered: pwr_r, channel: chan_r};

endmodule : sac_ctrl

// File: test/sac_host.sv
// Host serial port model: select, serial clock, frame capture
`timescale 1ns/100ps
module sac_host (
  // Clock
  input  wire logic sys_clk,
  // Pins
  output logic      sclk,
  output logic      cs_n,
  input  wire logic sdo_o,
  input  wire logic sdo_oe_n,
  input  wire logic result_invalid,
  // Captured frame
  output logic [15:0] word,
  output logic        inval
);
  logic line_r;
  // Released line shows the inverse of the last bit, never a stale value
  always_ff @(posedge sys_clk) if (!sdo_oe_n) line_r <= sdo_o;
  wire sdo_line = sdo_oe_n ? ~line_r : sdo_o;
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    word = 16'h0000;
    inval = 1'b0;
  end
  // Half of a 160 ns period, inside every mode limit
  task automatic half();
    repeat (4) @(posedge sys_clk);
    #1;
  endtask : half
  task automatic frame(input int n);
    cs_n = 1'b0;
    half();
    half();
    inval = result_invalid;
    for (int i = 0; i < n; i++) begin
      // Taken late in the low phase, well after the bit settles
      if (i < 16) word = {word[14:0], sdo_line};
      sclk = 1'b1;
      half();
      sclk = 1'b0;
      half();
    end
    cs_n = 1'b1;
    half();
    sclk = 1'b1;
    half();
    sclk = 1'b0;
    half();
    half();
  endtask : frame
endmodule : sac_host

// File: test/sac_ctrl_checker.sv
// Assertion checker for the converter cycle control
`timescale 1ns/100ps
module sac_ctrl_checker (
  // Clock and reset
  input wire logic                   sys_clk,
  input wire logic                   nrst,
  // Host pins
  input wire logic                   sclk,
  input wire logic                   cs_n,
  input wire logic                   frame_sync_in,
  input wire logic                   sdo_oe_n,
  // Front end
  input wire sac_pkg::sac_frontend_s frontend
);
  import sac_pkg::*;
  logic       sclk_r, sclk_nxt;
  logic [7:0] rise_r, rise_nxt, fall_r, fall_nxt;
  // Raw pin edges, counted per select-low cycle
  always_comb begin
    sclk_nxt = sclk;
    rise_nxt = cs_n ? 8'h00 : rise_r + 8'(sclk && !sclk_r);
    fall_nxt = cs_n ? 8'h00 : fall_r + 8'(!sclk && sclk_r);
  end
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      sclk_r <= 1'b0;
      rise_r <= 8'h00;
      fall_r <= 8'h00;
    end else begin
      sclk_r <= sclk_nxt;
      rise_r <= rise_nxt;
      fall_r <= fall_nxt;
    end
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  property p_idle_hiz; (cs_n && frame_sync_in) [*6] |-> sdo_oe_n; endproperty
  a_idle_hiz: assert property (p_idle_hiz) else $error("driven while idle");
  property p_start; $fell(cs_n) && frame_sync_in |-> ##[1:6] !sdo_oe_n; endproperty
  a_start: assert property (p_start) else $error("no drive at start");
  property p_wake; $fell(cs_n) |-> ##[1:6] frontend.powered; endproperty
  a_wake: assert property (p_wake) else $error("no wake");
  property p_rel17; rise_r == 8'h11 |-> ##[0:6] sdo_oe_n; endproperty
  a_rel17: assert property (p_rel17) else $error("no release");
  property p_samp; $rose(frontend.sample_en) |-> fall_r == 8'h04; endproperty
  a_samp: assert property (p_samp) else $error("sample start off");
  property p_conv; $rose(frontend.convert_en) |-> fall_r == 8'h10; endproperty
  a_conv: assert property (p_conv) else $error("convert start off");
  property p_done; $fell(frontend.convert_en) && !cs_n |-> fall_r == 8'h2c; endproperty
  a_done: assert property (p_done) else $error("convert length off");
  property p_pdown; $fell(frontend.convert_en) && !cs_n |-> ##[0:2] !frontend.powered;
  endproperty
  a_pdown: assert property (p_pdown) else $error("no power down");
  property p_abort; $rose(cs_n) && frontend.convert_en |-> ##[1:6] !frontend.convert_en;
  endproperty
  a_abort: assert property (p_abort) else $error("no abort");
  c_abort: cover property ($rose(cs_n) && frontend.convert_en);
  c_done: cover property ($fell(frontend.convert_en) && !cs_n);
  c_short: cover property ($rose(cs_n) && rise_r == 8'h04);
endmodule : sac_ctrl_checker
bind sac_ctrl sac_ctrl_checker sac_ctrl_checker_i (.sys_clk, .nrst, .sclk, .cs_n,
  .frame_sync_in, .sdo_oe_n, .frontend);

// File: test/tb_serial_adc_cycle_control.sv
// Self-checking bench for the converter cycle control
`timescale 1ns/100ps
module tb_serial_adc_cycle_control;
  import sac_pkg::*;
  logic          sys_clk, nrst, sclk, cs_n, sdo_o, sdo_oe_n, result_invalid, inval;
  logic          dsp_sel, fsync;
  logic [15:0]   word;
  sac_variant_e  variant;
  sac_analog_s   analog;
  sac_frontend_s frontend;
  int            fail_count, n_compared;
  sac_ctrl sac_ctrl_i (.sys_clk, .nrst, .variant, .dsp_select_mode(dsp_sel), .sclk, .cs_n,
    .frame_sync_in(fsync), .sdo_o, .sdo_oe_n, .analog, .frontend, .result_invalid);
  sac_host sac_host_i (.sys_clk, .sclk, .cs_n, .sdo_o, .sdo_oe_n, .result_invalid,
    .word, .inval);
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check_w(input string what, input logic [15:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask : check_w
  task automatic check_b(input string what, input logic exp, got);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected %s: expected %b, seen %b", what, exp, got);
    end
  endtask : check_b
  task automatic summarize();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  ////////////////////////////////////////////////////////////////////////////////
  // Each frame shows the previous frame's result, rails included
  task automatic t_pipeline();
    logic [13:0] stim [4];
    logic [11:0] res  [4];
    stim = '{14'h0a5c, 14'h03c1, 14'h2123, 14'h17ff};
    res  = '{12'ha5c, 12'h3c1, CODE_FULL, CODE_ZERO};
    variant = SAC_VAR_SINGLE;
    for (int i = 0; i < 5; i++) begin
      analog = stim[i % 4];
      sac_host_i.frame(45);
      check_w("word", (i == 0) ? 16'h0000 : {res[i - 1], 4'h0}, word);
      check_b("invalid", 1'b0, inval);
    end
  endtask : t_pipeline
  task automatic t_abort();
    analog = 14'h0abc;
    sac_host_i.frame(20);
    sac_host_i.frame(45);
    check_b("invalid", 1'b1, inval);
    sac_host_i.frame(45);
    check_b("invalid", 1'b0, inval);
    check_w("word", 16'habc0, word);
  endtask : t_abort
  // Short cycles at both window bounds and just past the upper one
  task automatic t_channel();
    int   len [5];
    logic ch  [5];
    len = '{4, 45, 8, 45, 7};
    ch  = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0};
    variant = SAC_VAR_DUAL;
    for (int i = 0; i < 5; i++) begin
      sac_host_i.frame(len[i]);
      check_b("channel", ch[i], frontend.channel);
    end
  endtask : t_channel
  // DSP frame on select: data moves on the falling serial clock edge
  task automatic t_dsp();
    variant = SAC_VAR_SINGLE;
    dsp_sel = 1'b1;
    analog = 14'h0123;
    sac_host_i.frame(45);
    check_w("dsp word", 16'habc0, word);
    sac_host_i.frame(45);
    check_w("dsp word", 16'h1230, word);
    dsp_sel = 1'b0;
  endtask : t_dsp
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    #400000;
    fail_count++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    variant = SAC_VAR_SINGLE;
    analog = '0;
    dsp_sel = 1'b0;
    fsync = 1'b1;
    fail_count = 0;
    n_compared = 0;
    repeat (10) @(posedge sys_clk);
    #1 nrst = 1'b1;
    repeat (3) @(posedge sys_clk);
    #1;
    t_pipeline();
    t_abort();
    t_channel();
    t_dsp();
    summarize();
  end
endmodule : tb_serial_adc_cycle_control
